// ### hdl/pmt_pkg.sv
/*
  constants, carrier structs and state types of the prescaled match timer.
  assumes a 32-bit classic wishbone master with byte addressing.
*/
package pmt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h04;
  localparam logic [7:0] MATCH_IDX = 8'h05;
  localparam logic [7:0] COUNT_IDX = 8'h06;
  localparam logic [7:0] ISTAT_IDX = 8'h08;
  localparam logic [7:0] IMASK_IDX = 8'h09;
  localparam int ADR_W = 10;
  localparam int IDX_LO = 2;

  // timer_control field positions
  localparam int PSS_LO = 0;
  localparam int PSS_HI = 2;
  localparam int SRC_BIT = 3;
  localparam int RUN_BIT = 4;
  localparam int VALID_BIT = 5;
  localparam int FLAG_BIT = 6;
  localparam int IE_BIT = 7;

  // reset values, the blank read value and the increment steps
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_BLANK = 8'h00;
  localparam logic [10:0] PRE_RESET = 11'h000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [10:0] PRE_ONE = 11'h001;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // prescaler divide codes 000..111: /1 /4 /16 /64 /256 /512 /1024 /2048
  function automatic logic [10:0] pmt_pre_mask(input logic [2:0] code);
    case (code)
      3'h0: pmt_pre_mask = 11'h000;
      3'h1: pmt_pre_mask = 11'h003;
      3'h2: pmt_pre_mask = 11'h00f;
      3'h3: pmt_pre_mask = 11'h03f;
      3'h4: pmt_pre_mask = 11'h0ff;
      3'h5: pmt_pre_mask = 11'h1ff;
      3'h6: pmt_pre_mask = 11'h3ff;
      default: pmt_pre_mask = 11'h7ff;
    endcase
  endfunction

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } pmt_bus_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } pmt_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pmt_wb_rsp_type;

  typedef struct packed {
    pmt_bus_type bus;
    logic [31:0] rdData;
    logic [7:0] ctrl;
    logic [7:0] matchValue;
    logic [7:0] countValue;
    logic [10:0] pre;
    logic slowPrev;
    logic matchStatus;
    logic matchMask;
  } pmt_state_type;

endpackage

// ### hdl/pmt_timer.sv
/*
  prescaled match timer with a wishbone classic register slave.
  assumes a 32-bit wishbone master on ref_clk, and a 32 kHz clock
  level already synchronous to ref_clk; stop mode is only observed.
  register map, byte addresses, data in bits 7:0 of each word:
    0x10 timer_control, 0x14 match_value, 0x18 count_value,
    0x20 interrupt status (read clears), 0x24 interrupt mask.
  every access is answered one cycle after it is taken, so the
  master needs no wait-state logic of its own; unmapped words read 0.
  the slow clock must stay low for at least one ref_clk cycle between
  rises, or a rise is missed; at 32 kHz against 20 MHz that is no limit.
*/
`timescale 1ns/1ps

module pmt_timer
  import pmt_pkg::*;
(
  input wire logic ref_clk, // system clock, 20 MHz
  input wire logic reset_n, // asynchronous reset, active low
  input wire pmt_wb_req_type wbReq, // wishbone request group
  output pmt_wb_rsp_type wbRsp, // wishbone answer group
  input wire logic slowClk, // 32 kHz clock level
  input wire logic stopMode, // low-power stop state
  output logic intReq // level interrupt request
);

  pmt_state_type state;
  pmt_state_type next_state;

  // decoded request
  // only the low byte lane carries register data
  logic access;
  logic doWrite;
  logic lowLane;
  logic [7:0] idx;
  logic [7:0] wrByte;

  // timer datapath terms
  logic slowEdge;
  logic srcEdge;
  logic running;
  logic onSlow;
  logic [10:0] preMask;
  logic tick;
  logic hit;
  logic frozen;

  // read views of the count and control registers
  // slow-clock reads are blanked while the count may be moving
  logic [7:0] countView;
  logic [7:0] ctrlView;

  // request decode; index taken from word address
  always_comb
  begin
    access = wbReq.cyc && wbReq.stb;
    idx = wbReq.adr[ADR_W-1:IDX_LO];
    lowLane = wbReq.sel[0];
    wrByte = wbReq.dat[7:0];
    // write lands on the edge that samples ack high
    // so it coincides exactly with the edge the master takes as done
    doWrite = access && wbReq.we && lowLane
      && (state.bus == BUS_ACK);
  end

  // source edge selection
  // the slow level is compared with its value one cycle back,
  // so a rise counts once however long the level stays high
  always_comb
  begin
    onSlow = state.ctrl[SRC_BIT];
    running = state.ctrl[RUN_BIT];
    slowEdge = slowClk && !state.slowPrev;
    // source select
    // system clock ticks every edge, slow one on its rise
    srcEdge = onSlow ? slowEdge : 1'b1;
  end

  // prescaler and match compare
  // a tick is one prescaled source edge; the compare only looks
  // at the count on a tick, so a count written to the match value
  // by software does not raise the flag until the next tick
  always_comb
  begin
    preMask = pmt_pre_mask(state.ctrl[PSS_HI:PSS_LO]);
    // stop mode
    // stopMode is deliberately not a term here:
    // the timer keeps running through low power
    // a caller that gates ref_clk in stop mode stops the timer too;
    // the clock must keep running for this guarantee to hold
    tick = running && srcEdge
      && ((state.pre & preMask) == preMask);
    hit = tick && (state.countValue == state.matchValue);
    // the lock uses the run bit in force before the write,
    // so one write cannot both halt and reprogram the timer
    // field lock
    frozen = running;
  end

  // register read views
  // reads are captured when the request is taken, one cycle
  // before ack, so the view must be settled at that edge
  always_comb
  begin
    if (onSlow && !state.ctrl[VALID_BIT])
      countView = COUNT_BLANK;
    else
      countView = state.countValue;
    ctrlView = state.ctrl;
  end

  // next state of the whole block
  // later assignments below override earlier ones; the order
  // encodes the priorities: bus, then software, then hardware set
  always_comb
  begin
    next_state = state;
    next_state.slowPrev = slowClk;

    // prescaler runs only with the timer;
    // halting it restarts the divide phase cleanly
    // the divide phase also restarts on every tick, so each code
    // gives exactly its divisor in source edges per count step
    if (!running)
      next_state.pre = PRE_RESET;
    else if (tick)
      next_state.pre = PRE_RESET;
    else if (srcEdge)
      next_state.pre = state.pre + PRE_ONE;

    // counter: increment per tick, wrap at match
    // the count also wraps at 8 bits when the match value is
    // never reached, which leaves the flag untouched
    if (hit)
    begin
      next_state.countValue = COUNT_RESET;
    end
    else if (tick)
    begin
      next_state.countValue = state.countValue + COUNT_ONE;
    end

    // count is unsettled in the cycle a slow edge lands;
    // software reading it then sees zero instead of a torn value
    // on the system clock the flag means nothing and stays high
    next_state.ctrl[VALID_BIT] = !(onSlow && slowEdge);

    // bus sequencing: one wait state, then ack
    // the answer is always one cycle late, which keeps ack a
    // registered decision and leaves the read mux off the bus path
    case (state.bus)
      BUS_IDLE:
      begin
        if (access)
        begin
          next_state.bus = BUS_ACK;
          next_state.rdData = DATA_ZERO;
          case (idx)
            CTRL_IDX: next_state.rdData[7:0] = ctrlView;
            MATCH_IDX: next_state.rdData[7:0] = state.matchValue;
            COUNT_IDX: next_state.rdData[7:0] = countView;
            ISTAT_IDX: next_state.rdData[0] = state.matchStatus;
            IMASK_IDX: next_state.rdData[0] = state.matchMask;
            default: next_state.rdData = DATA_ZERO;
          endcase
        end
      end
      BUS_ACK:
      begin
        next_state.bus = BUS_IDLE;
      end
      default:
      begin
        next_state.bus = BUS_IDLE;
      end
    endcase

    // software writes
    // run and enable are always writable so software can halt
    // a running timer; the locked fields need a separate write
    if (doWrite)
    begin
      case (idx)
        CTRL_IDX:
        begin
          next_state.ctrl[RUN_BIT] = wrByte[RUN_BIT];
          next_state.ctrl[IE_BIT] = wrByte[IE_BIT];
          if (!frozen)
          begin
            next_state.ctrl[PSS_HI:PSS_LO] = wrByte[PSS_HI:PSS_LO];
            next_state.ctrl[SRC_BIT] = wrByte[SRC_BIT];
          end
          // the valid bit is read-only; hardware owns it
          // software clear
          // writing one leaves the flag as it is
          if (!wrByte[FLAG_BIT])
            next_state.ctrl[FLAG_BIT] = 1'b0;
        end
        MATCH_IDX:
        begin
          // the lock follows the source bit in force before the write
          // match value
          if (!onSlow)
            next_state.matchValue = wrByte;
        end
        COUNT_IDX:
        begin
          if (!onSlow)
            next_state.countValue = wrByte;
        end
        IMASK_IDX:
        begin
          // mask only gates the status path of the interrupt
          next_state.matchMask = wrByte[0];
        end
        default:
        begin
          next_state.matchMask = state.matchMask;
        end
      endcase
    end

    // read of the status register clears it at ack
    // only an event that the read has reported is cleared:
    // one that lands between capture and ack stays pending
    // and would otherwise be lost without an interrupt
    if (access && !wbReq.we && (state.bus == BUS_ACK)
      && (idx == ISTAT_IDX) && state.rdData[0])
      next_state.matchStatus = 1'b0;

    // set beats clear
    // hardware set comes last so a same-cycle clear loses
    if (hit)
    begin
      next_state.ctrl[FLAG_BIT] = 1'b1;
      next_state.matchStatus = 1'b1;
    end
  end

  // reset clears control
  // all state registered in one place
  // the reset branch only loads constants, so a reset in the
  // middle of a bus cycle leaves no half-written register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state.bus <= BUS_IDLE;
      state.rdData <= DATA_ZERO;
      state.ctrl <= CTRL_RESET;
      state.matchValue <= MATCH_RESET;
      state.countValue <= COUNT_RESET;
      state.pre <= PRE_RESET;
      state.slowPrev <= 1'b0;
      state.matchStatus <= 1'b0;
      state.matchMask <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // answer and interrupt outputs
  // ack needs the live strobe so it falls the moment the
  // master withdraws; the read data itself comes from a flop
  always_comb
  begin
    wbRsp.ack = (state.bus == BUS_ACK) && access;
    wbRsp.dat = state.rdData;
    intReq = (state.ctrl[FLAG_BIT] && state.ctrl[IE_BIT])
      || (state.matchStatus && state.matchMask);
  end

endmodule

// ### verification/pmt_timer_sva.sv
/* checker: readback and interrupt gating of pmt_timer.
   assumes it sees only the top ports, bound below. */
`timescale 1ns/1ps
module pmt_timer_sva import pmt_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic reset_n, // reset, active low
  input wire pmt_wb_req_type wbReq, // bus request
  input wire pmt_wb_rsp_type wbRsp, // bus answer
  input wire logic slowClk, // slow clock level
  input wire logic stopMode, // stop state
  input wire logic intReq // interrupt level
);
  logic src, run, ie, msk, wr, ctrlRd, matchRd;
  logic [2:0] pss;
  logic [7:0] mv;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // strobes for accepted writes and reads
  assign wr = wbRsp.ack && wbReq.we && wbReq.sel[0];
  assign ctrlRd = wbRsp.ack && !wbReq.we && wbReq.adr == 10'h010;
  assign matchRd = wbRsp.ack && !wbReq.we && wbReq.adr == 10'h014;
  // shadow of software fields; frozen ones only move while halted
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      {src, run, ie, msk, pss, mv} <= '0;
    else if (wr)
    begin
      if (wbReq.adr == 10'h010)
      begin
        if (!run)
          {src, pss} <= wbReq.dat[3:0];
        run <= wbReq.dat[4];
        ie <= wbReq.dat[7];
      end
      if (wbReq.adr == 10'h014 && !src)
        mv <= wbReq.dat[7:0];
      if (wbReq.adr == 10'h024)
        msk <= wbReq.dat[0];
    end
  a_pss_frozen: assert property (ctrlRd |-> wbRsp.dat[2:0] == pss)
    else $error("prescale readback wrong");
  a_src_frozen: assert property (ctrlRd |-> wbRsp.dat[3] == src)
    else $error("source readback wrong");
  a_run_bit: assert property (ctrlRd |-> wbRsp.dat[4] == run)
    else $error("run readback wrong");
  a_ie_bit: assert property (ctrlRd |-> wbRsp.dat[7] == ie)
    else $error("enable readback wrong");
  a_ctrl_width: assert property (ctrlRd |-> wbRsp.dat[31:8] == 24'h000000)
    else $error("control upper bits set");
  a_match_guard: assert property (matchRd |-> wbRsp.dat == {24'h000000, mv})
    else $error("match value wrong");
  a_reset_quiet: assert property ($rose(reset_n) |-> !intReq && !wbRsp.ack)
    else $error("outputs active after reset");
  a_irq_gated: assert property (!ie && !msk |-> !intReq)
    else $error("interrupt while disabled");
  a_flag_irq: assert property (ctrlRd && wbRsp.dat[6] && wbRsp.dat[7] |-> intReq)
    else $error("flag and enable without interrupt");
endmodule

bind pmt_timer pmt_timer_sva pmt_timer_sva_inst (.ref_clk(ref_clk), .reset_n(reset_n), .wbReq(wbReq),
  .wbRsp(wbRsp), .slowClk(slowClk), .stopMode(stopMode), .intReq(intReq));

// ### verification/tb_top.sv
/* bench: register-level tests of pmt_timer over wishbone.
   assumes the bound checker and a 50 ns clock. */
`timescale 1ns/1ps
module tb_top import pmt_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic slowClk = 1'b0;
  logic stopMode = 1'b0;
  logic intReq;
  pmt_wb_req_type wbReq = '0;
  pmt_wb_rsp_type wbRsp;
  logic [31:0] q, e;
  int n_errors = 0;
  int check_count = 0;

  pmt_timer pmt_timer_inst (.ref_clk(ref_clk), .reset_n(reset_n), .wbReq(wbReq), .wbRsp(wbRsp),
    .slowClk(slowClk), .stopMode(stopMode), .intReq(intReq));

  // 20 MHz clock
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // one classic cycle; ack and read data are taken at the rising edge,
  // the request held until then and dropped for one idle cycle after
  task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wbReq <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbRsp.ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      $display("Error at %0t: ack %h expected %h", $time, wbRsp.ack, 1'b1);
      n_errors++;
      wrap_up();
    end
    else
    begin
      q = wbRsp.dat;
      wbReq.cyc <= 1'b0;
      wbReq.stb <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task automatic rc(input logic [9:0] a, input logic [31:0] x);
    bus(a, 1'b0, 32'h0);
    chk(q, x);
  endtask

  // interrupt level is sampled away from the edges
  task automatic irq(input logic x);
    @(negedge ref_clk);
    chk({31'h0, intReq}, {31'h0, x});
    @(posedge ref_clk);
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rc(10'h010, 32'h20);
    rc(10'h014, 32'h0);
    rc(10'h018, 32'h0);
    rc(10'h020, 32'h0);
    rc(10'h3fc, 32'h0);
    irq(1'b0);
    $display("reset test done");
    // all divide codes, with stop mode held to show it does not freeze counting
    stopMode <= 1'b1;
    bus(10'h014, 1'b1, 32'hff);
    for (int c = 0; c < 8; c++)
    begin
      bus(10'h018, 1'b1, 32'h0);
      bus(10'h010, 1'b1, 32'h10 | c);
      repeat (61) @(posedge ref_clk);
      bus(10'h010, 1'b1, c);
      bus(10'h018, 1'b0, 32'h0);
      e = c < 4 ? 32'h40 >> (2 * c) : 32'h0;
      chk({31'h0, q <= e + 1 && q + 1 >= e}, 32'h1);
    end
    $display("prescale test done");
    bus(10'h010, 1'b1, 32'h13);
    bus(10'h010, 1'b1, 32'h1c);
    bus(10'h010, 1'b0, 32'h0);
    chk(q & 32'h1f, 32'h13);
    bus(10'h010, 1'b1, 32'h03);
    $display("frozen field test done");
    // slow source counts only slow-clock rises; match and count writes locked
    bus(10'h018, 1'b1, 32'h0);
    bus(10'h010, 1'b1, 32'h08);
    bus(10'h014, 1'b1, 32'h33);
    rc(10'h014, 32'hff);
    bus(10'h010, 1'b1, 32'h18);
    repeat (8)
    begin
      repeat (5) @(posedge ref_clk);
      slowClk <= ~slowClk;
    end
    repeat (5) @(posedge ref_clk);
    bus(10'h010, 1'b1, 32'h08);
    rc(10'h018, 32'h4);
    bus(10'h018, 1'b1, 32'h55);
    rc(10'h018, 32'h4);
    // a slow rise blanks the count read in the following cycle
    slowClk <= 1'b1;
    @(posedge ref_clk);
    rc(10'h018, 32'h0);
    bus(10'h010, 1'b1, 32'h00);
    $display("slow source test done");
    // match at zero keeps the count at zero and raises the flag
    bus(10'h018, 1'b1, 32'h0);
    bus(10'h014, 1'b1, 32'h0);
    bus(10'h010, 1'b1, 32'h10);
    bus(10'h010, 1'b1, 32'h40);
    irq(1'b0);
    rc(10'h010, 32'h60);
    rc(10'h018, 32'h0);
    bus(10'h010, 1'b1, 32'hc0);
    irq(1'b1);
    repeat (5) @(posedge ref_clk);
    rc(10'h010, 32'he0);
    bus(10'h010, 1'b1, 32'h80);
    irq(1'b0);
    bus(10'h024, 1'b1, 32'h1);
    irq(1'b1);
    rc(10'h020, 32'h1);
    irq(1'b0);
    rc(10'h020, 32'h0);
    $display("interrupt test done");
    // a reset in mid-run clears control, match and the interrupt
    bus(10'h014, 1'b1, 32'h5a);
    bus(10'h018, 1'b1, 32'h5a);
    bus(10'h010, 1'b1, 32'h90);
    irq(1'b1);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rc(10'h010, 32'h20);
    rc(10'h014, 32'h0);
    irq(1'b0);
    $display("second reset test done");
    wrap_up();
  end

  // hang guard, well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
endmodule
